// *** bench/rsc_chk.sv ***
// Port-level assertions for the roller-shutter relay controller.
// Assumes binding to rsc_top; sees only its ports.
`timescale 1ns/100ps
`include "rsc_cfg.svh"
module rsc_chk
    import rsc_pkg::*;
(
    input wire logic        clk_i,                 // clock
    input wire logic        rst_i,                 // reset
    input wire logic        cyc_i,                 // cycle
    input wire logic        stb_i,                 // strobe
    input wire logic        we_i,                  // write
    input wire logic [7:0]  adr_i,                 // address
    input wire logic [3:0]  sel_i,                 // lanes
    input wire logic [31:0] dat_i,                 // write data
    input wire logic        ack_o,                 // acknowledge
    input wire logic        raise_relay_o,         // up relay
    input wire logic        lower_relay_o,         // down relay
    input wire rsc_code_t   motion_state_o,        // code
    input wire logic        output_change_event_o, // change
    input wire logic        raise_begin_event_o,   // up begin
    input wire logic        lower_begin_event_o,   // down begin
    input wire logic        start_request_event_o, // start
    input wire logic        stop_request_event_o   // stop
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    logic req_w;
    logic cmd_w;
    // A command is taken only on an unanswered request with lane 0 on
    assign req_w = cyc_i && stb_i && !ack_o;
    assign cmd_w = req_w && we_i && adr_i == `RSC_ADR_CMD && sel_i[0];

    a_relay_excl: assert property (!(raise_relay_o && lower_relay_o))
        else $error("both relays on");
    a_ack_next: assert property (req_w |=> ack_o)
        else $error("request not acknowledged");
    a_change_ev: assert property ($changed(raise_relay_o) ||
        $changed(lower_relay_o) |-> output_change_event_o)
        else $error("relay change without event");
    a_raise_ev: assert property (raise_begin_event_o ==
        (motion_state_o == RSC_CODE_UP && $past(motion_state_o) == 2'h0))
        else $error("raise begin event wrong");
    a_lower_ev: assert property (lower_begin_event_o ==
        (motion_state_o == RSC_CODE_DOWN && $past(motion_state_o) == 2'h0))
        else $error("lower begin event wrong");
    a_stop_halts: assert property (cmd_w && dat_i[2:0] == RSC_CMD_STOP
        |=> ##1 !raise_relay_o && !lower_relay_o && motion_state_o == 2'h0)
        else $error("stop did not halt");
    a_start_ev: assert property (cmd_w && dat_i[2:0] == RSC_CMD_START
        |-> ##[1:3] start_request_event_o)
        else $error("start event missing");
    a_stop_ev: assert property (cmd_w && dat_i[2:0] == RSC_CMD_STOP
        |=> stop_request_event_o)
        else $error("stop event missing");
    a_reset_out: assert property ($fell(rst_i) |-> !raise_relay_o &&
        !lower_relay_o && motion_state_o == RSC_CODE_STOPPED)
        else $error("outputs active after reset");
endmodule

bind rsc_top rsc_chk u_chk (.*);

// *** bench/rsc_ctl.sv ***
// Controller-side model: classic Wishbone master for the relay block.
// Assumes a clock shared with the block; tasks start after an edge.
`timescale 1ns/100ps
module rsc_ctl #(
    parameter int unsigned BOOT_WAIT = 100
) (
    input  wire logic        clk_i,  // clock
    input  wire logic        ack_i,  // acknowledge
    input  wire logic [31:0] rdat_i, // read data
    output logic             cyc_o,  // cycle
    output logic             stb_o,  // strobe
    output logic             we_o,   // write
    output logic [7:0]       adr_o,  // address
    output logic [3:0]       sel_o,  // lanes
    output logic [31:0]      dat_o   // write data
);
    logic booted = 1'b0;
    // A request unanswered after a few cycles counts as a failed exchange
    int   link_failure_count = 0;
    logic link_banned;
    assign link_banned = (link_failure_count >= 3);
    initial begin
        {cyc_o, stb_o, we_o, adr_o, sel_o, dat_o} = 47'h0;
    end
    task automatic xfer(input logic w, input logic [7:0] a,
                        input logic [31:0] d, output logic [31:0] q);
        int waits = 0;
        // Ten scaled seconds of quiet before the first request
        if (!booted) begin
            repeat (BOOT_WAIT) @(posedge clk_i);
            booted = 1'b1;
        end
        cyc_o <= 1'b1;
        stb_o <= 1'b1;
        we_o  <= w;
        adr_o <= a;
        sel_o <= 4'hF;
        dat_o <= d;
        @(posedge clk_i);
        while (ack_i !== 1'b1) begin
            @(posedge clk_i);
            waits++;
            if (waits == 4) link_failure_count++;
        end
        q = rdat_i;
        cyc_o <= 1'b0;
        stb_o <= 1'b0;
        dat_o <= ~d;
        @(posedge clk_i);
    endtask
endmodule

// *** bench/tb_top.sv ***
// Testbench: bus commands, local inputs and the housing button.
// Assumes a ten-cycle second and the controller model as master.
`timescale 1ns/100ps
`include "rsc_cfg.svh"
module tb_top;
    import rsc_pkg::*;
    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        cyc_i, stb_i, we_i, ack_o, joined_o;
    logic        raise_relay_o, lower_relay_o;
    logic        latching_switch_input_i, push_button_input_i;
    logic        housing_button_i, inclusion_mode_i, exclusion_mode_i;
    logic        output_change_event_o, raise_begin_event_o;
    logic        lower_begin_event_o, start_request_event_o;
    logic        stop_request_event_o;
    logic [7:0]  adr_i;
    logic [3:0]  sel_i;
    logic [31:0] dat_i, dat_o, q;
    rsc_code_t   motion_state_o;
    int          fails = 0;
    int          check_count = 0;
    always #5 clk_i = ~clk_i;
    rsc_top #(.TICK_CYCLES(10)) u_dut (.*);
    rsc_ctl u_ctl (.clk_i(clk_i), .ack_i(ack_o), .rdat_i(dat_o),
        .cyc_o(cyc_i), .stb_o(stb_i), .we_o(we_i), .adr_o(adr_i),
        .sel_o(sel_i), .dat_o(dat_i));
    task automatic chk(input string n, input logic [31:0] s, e);
        check_count++;
        if (s !== e) begin
            fails++;
            $display("[ERR] %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic end_sim();
        $display("checks %0d mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk_i);
    endtask
    task automatic rw(input logic w, input logic [7:0] a, input logic [31:0] d);
        u_ctl.xfer(w, a, d, q);
    endtask
    task automatic cmd(input rsc_cmd_t op, input logic [15:0] dur);
        rw(1'b1, `RSC_ADR_CMD, {dur, 13'h0000, op});
    endtask
    task automatic st(input logic [1:0] r, input rsc_code_t c);
        chk("relays", {30'h0, raise_relay_o, lower_relay_o}, {30'h0, r});
        chk("code", {30'h0, motion_state_o}, {30'h0, c});
    endtask
    // Click or press: held two cycles so the edge is seen once
    task automatic pulse(input logic btn);
        if (btn) housing_button_i <= 1'b1;
        else push_button_input_i <= 1'b1;
        tick(2);
        {housing_button_i, push_button_input_i} <= 2'h0;
        tick(3);
    endtask
    task automatic t_reset();
        rw(1'b0, `RSC_ADR_STATUS, 32'h0);
        chk("status", {25'h0, q[6:0]}, 32'h00000020);
        rw(1'b0, `RSC_ADR_DEF_DUR, 32'h0);
        chk("def dur", q, 32'h0);
        rw(1'b0, `RSC_ADR_CONFIG, 32'h0);
        chk("config", {16'h0, q[15:0]}, 32'h0000310B);
        rw(1'b0, 8'h18, 32'h0);
        chk("unmapped", q, 32'h0);
    endtask
    task automatic t_local();
        latching_switch_input_i <= 1'b1;
        tick(4);
        st(2'b10, RSC_CODE_STOPPED);
        latching_switch_input_i <= 1'b0;
        tick(4);
        st(2'b00, RSC_CODE_STOPPED);
        pulse(1'b0);
        st(2'b01, RSC_CODE_STOPPED);
        pulse(1'b0);
        st(2'b00, RSC_CODE_STOPPED);
        pulse(1'b0);
        st(2'b10, RSC_CODE_STOPPED);
        pulse(1'b0);
    endtask
    task automatic t_cmds();
        cmd(RSC_CMD_UP, 16'h0);
        st(2'b10, RSC_CODE_UP);
        cmd(RSC_CMD_UP, 16'h0);
        st(2'b00, RSC_CODE_STOPPED);
        cmd(RSC_CMD_DOWN, 16'h0);
        st(2'b01, RSC_CODE_DOWN);
        cmd(RSC_CMD_DOWN, 16'h0);
        st(2'b00, RSC_CODE_STOPPED);
        cmd(RSC_CMD_START, 16'h0);
        st(2'b10, RSC_CODE_UP);
        cmd(RSC_CMD_STOP, 16'h0);
        st(2'b00, RSC_CODE_STOPPED);
        rw(1'b0, `RSC_ADR_EVENTS, 32'h0);
        chk("events", q, 32'h0000001F);
        cmd(RSC_CMD_HOLD_DOWN, 16'h0);
        chk("hold down", {31'h0, lower_relay_o}, 32'h1);
        cmd(RSC_CMD_HOLD_UP, 16'h0);
        chk("hold up", {31'h0, raise_relay_o}, 32'h1);
        cmd(RSC_CMD_HOLD, 16'h0);
        chk("hold", {31'h0, lower_relay_o}, 32'h1);
        cmd(RSC_CMD_STOP, 16'h0);
    endtask
    task automatic t_timed();
        rw(1'b1, `RSC_ADR_DEF_DUR, 32'h2);
        cmd(RSC_CMD_DOWN, 16'h0);
        tick(15);
        st(2'b01, RSC_CODE_DOWN);
        tick(6);
        st(2'b00, RSC_CODE_STOPPED);
        cmd(RSC_CMD_UP, 16'h1);
        tick(4);
        st(2'b10, RSC_CODE_UP);
        tick(8);
        st(2'b00, RSC_CODE_STOPPED);
    endtask
    task automatic t_lock();
        rw(1'b1, `RSC_ADR_CONFIG, 32'h3102);
        rw(1'b0, `RSC_ADR_CONFIG, 32'h0);
        chk("locked", {16'h0, q[15:0]}, 32'h0000310B);
        rw(1'b1, `RSC_ADR_LOCK, 32'h0);
        rw(1'b1, `RSC_ADR_CONFIG, 32'h3102);
        rw(1'b0, `RSC_ADR_CONFIG, 32'h0);
        chk("unlocked", {16'h0, q[15:0]}, 32'h00003102);
    endtask
    task automatic t_join();
        inclusion_mode_i <= 1'b1;
        pulse(1'b1);
        chk("joined", {31'h0, joined_o}, 32'h1);
        rw(1'b0, `RSC_ADR_CONFIG, 32'h0);
        chk("join cfg", {16'h0, q[15:0]}, 32'h0000310B);
        inclusion_mode_i <= 1'b0;
        exclusion_mode_i <= 1'b1;
        repeat (5) pulse(1'b1);
        chk("five", {31'h0, joined_o}, 32'h1);
        pulse(1'b1);
        chk("six", {31'h0, joined_o}, 32'h0);
    endtask
    initial begin
        latching_switch_input_i = 1'b0;
        {push_button_input_i, housing_button_i} = 2'h0;
        {inclusion_mode_i, exclusion_mode_i} = 2'h0;
        tick(10);
        rst_i <= 1'b0;
        tick(1);
        t_reset();
        t_local();
        t_cmds();
        t_timed();
        t_lock();
        t_join();
        chk("link fails", u_ctl.link_failure_count, 32'h0);
        chk("banned", {31'h0, u_ctl.link_banned}, 32'h0);
        end_sim();
    end
    initial begin
        tick(20000);
        fails++;
        $display("[ERR] watchdog expected done seen timeout");
        end_sim();
    end
endmodule

// *** logic/rsc_cfg.svh ***
// Constants of the roller-shutter relay controller: offsets, fields,
// reset values and timing counts. Included by bare name.
`ifndef RSC_CFG_SVH
`define RSC_CFG_SVH

// Timing
`define RSC_CLK_HZ        100000000
`define RSC_TICK_S        1

// Register byte offsets
`define RSC_ADR_CMD       8'h00
`define RSC_ADR_STATUS    8'h04
`define RSC_ADR_DEF_DUR   8'h08
`define RSC_ADR_EVENTS    8'h0C
`define RSC_ADR_CONFIG    8'h10
`define RSC_ADR_LOCK      8'h14

// Command register fields
`define RSC_CMD_OP_LSB    0
`define RSC_CMD_DUR_LSB   16

// Configuration register fields
`define RSC_CFG_TRAVEL_LSB 0
`define RSC_CFG_S1_LSB     8
`define RSC_CFG_S2_LSB     12

// Event bit positions
`define RSC_EV_CHANGE     0
`define RSC_EV_RAISE      1
`define RSC_EV_LOWER      2
`define RSC_EV_START      3
`define RSC_EV_STOP       4

// Reset and join defaults
`define RSC_TRAVEL_DEF    8'h0B
`define RSC_MODE_LATCH    4'h1
`define RSC_MODE_PUSH     4'h3
`define RSC_DEF_DUR_RST   16'h0000
`define RSC_LOCK_RST      1'b1
`define RSC_EXCL_LAST     3'h5

`endif

// *** logic/rsc_edge.sv ***
// Rise and fall detector for a synchronous input level.
// The input is taken as already synchronous to clk_i.
`timescale 1ns/100ps
module rsc_edge (
    input  wire logic clk_i,   // system clock
    input  wire logic rst_i,   // sync reset
    input  wire logic lvl_i,   // input level
    output logic      rise_o,  // low to high
    output logic      fall_o   // high to low
);
    logic prev_q;
    logic prev_d;

    always_comb begin
        prev_d = lvl_i;
        rise_o = lvl_i && !prev_q;
        fall_o = !lvl_i && prev_q;
    end

    // Reset to low so a switch held high at reset counts as a rise
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            prev_q <= 1'b0;
        end else begin
            prev_q <= prev_d;
        end
    end
endmodule

// *** logic/rsc_pkg.sv ***
// Types shared by the roller-shutter relay controller.
// Assumes the constants header is included by every user.
package rsc_pkg;

    typedef enum logic [2:0] {
        RSC_CMD_NONE      = 3'h0,
        RSC_CMD_UP        = 3'h1,
        RSC_CMD_DOWN      = 3'h2,
        RSC_CMD_START     = 3'h3,
        RSC_CMD_STOP      = 3'h4,
        RSC_CMD_HOLD      = 3'h5,
        RSC_CMD_HOLD_UP   = 3'h6,
        RSC_CMD_HOLD_DOWN = 3'h7
    } rsc_cmd_t;

    typedef enum logic [1:0] {
        RSC_CODE_STOPPED = 2'h0,
        RSC_CODE_UP      = 2'h1,
        RSC_CODE_DOWN    = 2'h2
    } rsc_code_t;

    typedef enum logic [2:0] {
        RSC_MOT_IDLE  = 3'b001,
        RSC_MOT_RAISE = 3'b010,
        RSC_MOT_LOWER = 3'b100
    } rsc_mot_t;

endpackage

// *** logic/rsc_tick.sv ***
// One-second enable pulse divider with a restart input.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/100ps
module rsc_tick #(
    parameter int unsigned CYCLES = 100
) (
    input  wire logic clk_i,   // system clock
    input  wire logic rst_i,   // sync reset
    input  wire logic clr_i,   // restart the period
    output logic      tick_o   // one-cycle enable
);
    logic [31:0] cnt_q;
    logic [31:0] cnt_d;
    logic        last;

    always_comb begin
        last = (cnt_q == 32'(CYCLES - 1));
        if (clr_i || last) begin
            cnt_d = 32'h00000000;
        end else begin
            cnt_d = cnt_q + 32'h00000001;
        end
        tick_o = last && !clr_i;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cnt_q <= 32'h00000000;
        end else begin
            cnt_q <= cnt_d;
        end
    end
endmodule

// *** logic/rsc_top.sv ***
// Roller-shutter relay controller: two relays, local switch inputs,
// commands and settings over a classic Wishbone slave.
// Assumes all inputs synchronous to clk_i; one 100 MHz clock.
//
// Design decisions made here: the address map and the Wishbone interface to the registers.
`timescale 1ns/100ps
`include "rsc_cfg.svh"
// Behaviour
// - On joining, load full travel time setting with default 11 seconds.
// - On joining, first local input defaults to latching switch mode 1.
// - On joining, second local input defaults to push button mode 3.
// - Latching input high: raise if last went down, else lower.
// - Latching input low: stop, both relays off.
// - Each click steps: raise, stop, lower, stop, by last direction.
// - Join on a button press in inclusion; leave after six in exclusion.
// - Motion code: 0 stopped, 1 moving up, 2 moving down.
// - Up starts raising or stops if moving; stop halts any motion.
// - Down starts lowering or stops if moving.
// - Start moves opposite to the preceding motion.
// - Nonzero duration times the relay; zero uses default duration.
// - Default travel duration setting reads 0 until specified.
// - Hold reverses each time, hold up raises, hold down lowers.
// - Output change event whenever either relay changes.
// - Raise or lower begin event when leaving the stopped code.
// - Start and stop request events on those commands.
// - Motion code follows commands only, never local inputs.
// - Settings except default duration writable only while unlocked; lock resets to 1.
module rsc_top
    import rsc_pkg::*;
#(
    parameter int unsigned TICK_CYCLES = `RSC_CLK_HZ * `RSC_TICK_S
) (
    input  wire logic        clk_i,                    // 100 MHz clock
    input  wire logic        rst_i,                    // sync reset, high
    input  wire logic        cyc_i,                    // Wishbone cycle
    input  wire logic        stb_i,                    // Wishbone strobe
    input  wire logic        we_i,                     // write enable
    input  wire logic [7:0]  adr_i,                    // byte address
    input  wire logic [3:0]  sel_i,                    // byte enables
    input  wire logic [31:0] dat_i,                    // write data
    output logic      [31:0] dat_o,                    // read data
    output logic             ack_o,                    // acknowledge
    input  wire logic        latching_switch_input_i,  // first input
    input  wire logic        push_button_input_i,      // second input
    input  wire logic        housing_button_i,         // button on case
    input  wire logic        inclusion_mode_i,         // network adds
    input  wire logic        exclusion_mode_i,         // network removes
    output logic             raise_relay_o,            // raise relay on
    output logic             lower_relay_o,            // lower relay on
    output rsc_code_t        motion_state_o,           // reported code
    output logic             joined_o,                 // in network
    output logic             output_change_event_o,    // relay changed
    output logic             raise_begin_event_o,      // stopped to up
    output logic             lower_begin_event_o,      // stopped to down
    output logic             start_request_event_o,    // start command
    output logic             stop_request_event_o      // stop command
);
    import rsc_pkg::*;

    rsc_mot_t    mot_q,     mot_d;
    rsc_code_t   code_q,    code_d;
    logic        last_up_q, last_up_d;
    logic        timed_q,   timed_d;
    logic        by_cmd_q,  by_cmd_d;
    logic [15:0] left_q,    left_d;
    logic [15:0] def_dur_q, def_dur_d;
    logic [7:0]  travel_q,  travel_d;
    logic [3:0]  s1_mode_q, s1_mode_d;
    logic [3:0]  s2_mode_q, s2_mode_d;
    logic        lock_q,    lock_d;
    logic        joined_q,  joined_d;
    logic [2:0]  excl_q,    excl_d;
    logic [4:0]  evs_q,     evs_d;
    logic [4:0]  ev_q,      ev_d;
    logic        ack_q,     ack_d;
    logic [31:0] dat_q,     dat_d;

    logic        tick;
    logic        restart;
    logic        s1_rise, s1_fall, s2_rise, s2_fall;
    logic        btn_rise;

    rsc_tick #(
        .CYCLES (TICK_CYCLES)
    ) u_tick (
        .clk_i  (clk_i),
        .rst_i  (rst_i),
        .clr_i  (restart),
        .tick_o (tick)
    );

    rsc_edge u_s1 (
        .clk_i  (clk_i),
        .rst_i  (rst_i),
        .lvl_i  (latching_switch_input_i),
        .rise_o (s1_rise),
        .fall_o (s1_fall)
    );

    rsc_edge u_s2 (
        .clk_i  (clk_i),
        .rst_i  (rst_i),
        .lvl_i  (push_button_input_i),
        .rise_o (s2_rise),
        .fall_o (s2_fall)
    );

    rsc_edge u_btn (
        .clk_i  (clk_i),
        .rst_i  (rst_i),
        .lvl_i  (housing_button_i),
        .rise_o (btn_rise),
        .fall_o ()
    );

    logic        wr;
    logic        cmd_v;
    rsc_cmd_t    op;
    logic [15:0] dur;
    logic [15:0] run_dur;
    logic        moving;
    logic        lat_rise, lat_fall, click;
    logic        go_up, go_dn, halt, untimed, from_cmd;
    logic [31:0] wmask;
    logic [31:0] cfg_word, cfg_new;

    always_comb begin
        mot_d     = mot_q;
        code_d    = code_q;
        last_up_d = last_up_q;
        timed_d   = timed_q;
        by_cmd_d  = by_cmd_q;
        left_d    = left_q;
        def_dur_d = def_dur_q;
        travel_d  = travel_q;
        s1_mode_d = s1_mode_q;
        s2_mode_d = s2_mode_q;
        lock_d    = lock_q;
        joined_d  = joined_q;
        excl_d    = excl_q;
        restart   = 1'b0;
        go_up     = 1'b0;
        go_dn     = 1'b0;
        halt      = 1'b0;
        untimed   = 1'b0;
        from_cmd  = 1'b0;
        ev_d      = 5'h00;

        // Bus answers one cycle after the strobe is seen
        ack_d = cyc_i && stb_i && !ack_q;
        wr    = ack_d && we_i;
        wmask = {{8{sel_i[3]}}, {8{sel_i[2]}}, {8{sel_i[1]}}, {8{sel_i[0]}}};
        cmd_v = wr && (adr_i == `RSC_ADR_CMD) && sel_i[0];
        op    = rsc_cmd_t'(dat_i[`RSC_CMD_OP_LSB +: 3]);
        dur   = dat_i[`RSC_CMD_DUR_LSB +: 16];
        moving = (mot_q != RSC_MOT_IDLE);

        // Zero duration falls back to the default, then to full travel
        if (dur != 16'h0000) begin
            run_dur = dur;
        end else if (def_dur_q != 16'h0000) begin
            run_dur = def_dur_q;
        end else begin
            run_dur = {8'h00, travel_q};
        end

        // Local inputs act by their configured modes
        lat_rise = ((s1_mode_q == `RSC_MODE_LATCH) && s1_rise)
                || ((s2_mode_q == `RSC_MODE_LATCH) && s2_rise);
        lat_fall = ((s1_mode_q == `RSC_MODE_LATCH) && s1_fall)
                || ((s2_mode_q == `RSC_MODE_LATCH) && s2_fall);
        click    = ((s1_mode_q == `RSC_MODE_PUSH) && s1_rise)
                || ((s2_mode_q == `RSC_MODE_PUSH) && s2_rise);

        if (cmd_v && (op != RSC_CMD_NONE)) begin
            from_cmd = 1'b1;
            case (op)
                RSC_CMD_UP: begin
                    halt  = moving;
                    go_up = !moving;
                end
                RSC_CMD_DOWN: begin
                    halt  = moving;
                    go_dn = !moving;
                end
                RSC_CMD_START: begin
                    go_up = !last_up_q;
                    go_dn = last_up_q;
                    ev_d[`RSC_EV_START] = 1'b1;
                end
                RSC_CMD_STOP: begin
                    halt = 1'b1;
                    ev_d[`RSC_EV_STOP] = 1'b1;
                end
                RSC_CMD_HOLD: begin
                    go_up   = !last_up_q;
                    go_dn   = last_up_q;
                    untimed = 1'b1;
                end
                RSC_CMD_HOLD_UP: begin
                    go_up   = 1'b1;
                    untimed = 1'b1;
                end
                RSC_CMD_HOLD_DOWN: begin
                    go_dn   = 1'b1;
                    untimed = 1'b1;
                end
                default: begin
                    halt = 1'b0;
                end
            endcase
        end else if (lat_fall) begin
            halt = 1'b1;
        end else if (lat_rise) begin
            go_up = !last_up_q;
            go_dn = last_up_q;
        end else if (click) begin
            halt  = moving;
            go_up = !moving && !last_up_q;
            go_dn = !moving && last_up_q;
        end

        // Local moves run at most one full travel time
        if (!from_cmd) begin
            run_dur = {8'h00, travel_q};
        end

        if (halt) begin
            mot_d   = RSC_MOT_IDLE;
            timed_d = 1'b0;
        end else if (go_up || go_dn) begin
            mot_d     = go_up ? RSC_MOT_RAISE : RSC_MOT_LOWER;
            last_up_d = go_up;
            timed_d   = !untimed;
            left_d    = run_dur;
            restart   = 1'b1;
        end else if (timed_q && moving && tick) begin
            if (left_q <= 16'h0001) begin
                mot_d   = RSC_MOT_IDLE;
                timed_d = 1'b0;
                if (by_cmd_q) begin
                    code_d = RSC_CODE_STOPPED;
                end
            end else begin
                left_d = left_q - 16'h0001;
            end
        end

        // The reported code moves only with commands
        if (from_cmd) begin
            by_cmd_d = 1'b1;
            if (halt) begin
                code_d = RSC_CODE_STOPPED;
            end else if (go_up) begin
                code_d = RSC_CODE_UP;
            end else if (go_dn) begin
                code_d = RSC_CODE_DOWN;
            end
        end else if (halt || go_up || go_dn) begin
            by_cmd_d = 1'b0;
        end

        ev_d[`RSC_EV_CHANGE] = (mot_d != mot_q);
        ev_d[`RSC_EV_RAISE]  = (code_q == RSC_CODE_STOPPED)
                            && (code_d == RSC_CODE_UP);
        ev_d[`RSC_EV_LOWER]  = (code_q == RSC_CODE_STOPPED)
                            && (code_d == RSC_CODE_DOWN);

        // Sticky copies: a new event beats a clear in the same cycle
        evs_d = evs_q;
        if (wr && (adr_i == `RSC_ADR_EVENTS) && sel_i[0]) begin
            evs_d = evs_q & ~dat_i[4:0];
        end
        evs_d = evs_d | ev_d;

        // Settings word, written only while unlocked
        cfg_word = {16'h0000, s2_mode_q, s1_mode_q, travel_q};
        cfg_new  = (cfg_word & ~wmask) | (dat_i & wmask);
        if (wr && (adr_i == `RSC_ADR_CONFIG) && !lock_q) begin
            travel_d  = cfg_new[`RSC_CFG_TRAVEL_LSB +: 8];
            s1_mode_d = cfg_new[`RSC_CFG_S1_LSB +: 4];
            s2_mode_d = cfg_new[`RSC_CFG_S2_LSB +: 4];
        end
        if (wr && (adr_i == `RSC_ADR_LOCK) && sel_i[0]) begin
            lock_d = dat_i[0];
        end
        if (wr && (adr_i == `RSC_ADR_DEF_DUR)) begin
            def_dur_d = (def_dur_q & ~wmask[15:0])
                      | (dat_i[15:0] & wmask[15:0]);
        end

        // Network membership through the housing button
        if (!exclusion_mode_i) begin
            excl_d = 3'h0;
        end
        if (btn_rise && inclusion_mode_i && !joined_q) begin
            joined_d  = 1'b1;
            travel_d  = `RSC_TRAVEL_DEF;
            s1_mode_d = `RSC_MODE_LATCH;
            s2_mode_d = `RSC_MODE_PUSH;
        end else if (btn_rise && exclusion_mode_i && joined_q) begin
            if (excl_q == `RSC_EXCL_LAST) begin
                joined_d = 1'b0;
                excl_d   = 3'h0;
            end else begin
                excl_d = excl_q + 3'h1;
            end
        end

        // Read mux; unmapped addresses read zero and ignore writes
        case (adr_i)
            `RSC_ADR_STATUS:  dat_d = {25'h0000000, joined_q, lock_q,
                                       last_up_q, mot_q[2], mot_q[1],
                                       code_q};
            `RSC_ADR_DEF_DUR: dat_d = {16'h0000, def_dur_q};
            `RSC_ADR_EVENTS:  dat_d = {27'h0000000, evs_q};
            `RSC_ADR_CONFIG:  dat_d = cfg_word;
            `RSC_ADR_LOCK:    dat_d = {31'h00000000, lock_q};
            default:          dat_d = 32'h00000000;
        endcase
        if (!ack_d || we_i) begin
            dat_d = dat_q;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            mot_q     <= RSC_MOT_IDLE;
            code_q    <= RSC_CODE_STOPPED;
            last_up_q <= 1'b0;
            timed_q   <= 1'b0;
            by_cmd_q  <= 1'b0;
            left_q    <= 16'h0000;
            def_dur_q <= `RSC_DEF_DUR_RST;
            travel_q  <= `RSC_TRAVEL_DEF;
            s1_mode_q <= `RSC_MODE_LATCH;
            s2_mode_q <= `RSC_MODE_PUSH;
            lock_q    <= `RSC_LOCK_RST;
            joined_q  <= 1'b0;
            excl_q    <= 3'h0;
            evs_q     <= 5'h00;
            ev_q      <= 5'h00;
            ack_q     <= 1'b0;
            dat_q     <= 32'h00000000;
        end else begin
            mot_q     <= mot_d;
            code_q    <= code_d;
            last_up_q <= last_up_d;
            timed_q   <= timed_d;
            by_cmd_q  <= by_cmd_d;
            left_q    <= left_d;
            def_dur_q <= def_dur_d;
            travel_q  <= travel_d;
            s1_mode_q <= s1_mode_d;
            s2_mode_q <= s2_mode_d;
            lock_q    <= lock_d;
            joined_q  <= joined_d;
            excl_q    <= excl_d;
            evs_q     <= evs_d;
            ev_q      <= ev_d;
            ack_q     <= ack_d;
            dat_q     <= dat_d;
        end
    end

    // Relay bits are the one-hot state flops themselves
    assign raise_relay_o         = mot_q[1];
    assign lower_relay_o         = mot_q[2];
    assign motion_state_o        = code_q;
    assign joined_o              = joined_q;
    assign output_change_event_o = ev_q[`RSC_EV_CHANGE];
    assign raise_begin_event_o   = ev_q[`RSC_EV_RAISE];
    assign lower_begin_event_o   = ev_q[`RSC_EV_LOWER];
    assign start_request_event_o = ev_q[`RSC_EV_START];
    assign stop_request_event_o  = ev_q[`RSC_EV_STOP];
    assign ack_o                 = ack_q;
    assign dat_o                 = dat_q;
endmodule
